/* File: dlcr_params.svh */
`ifndef DLCR_PARAMS_SVH
`define DLCR_PARAMS_SVH

// Register offsets on the serial control bus
`define DLCR_ADDR_GEN_CFG_ONE 8'h03
`define DLCR_ADDR_WDOG_CTRL 8'h04
`define DLCR_ADDR_BUS_CTRL_ONE 8'h05

// Reset values
`define DLCR_RST_GEN_CFG_ONE 8'hF0
`define DLCR_RST_WDOG_TIMEOUT 7'h7F
`define DLCR_RST_WDOG_OFF 1'h0
`define DLCR_RST_BUS_CTRL_ONE 8'h1E

// Field positions, general configuration one
`define DLCR_BIT_CHECK_GEN_OFF 6
`define DLCR_BIT_IDLE_PULL 5
`define DLCR_BIT_SYNC_FILTER 4
`define DLCR_BIT_PASS_DECODED 3
`define DLCR_BIT_AUTO_ACK 2
`define DLCR_BIT_COLOUR_MASK 1

// Field positions, watchdog control
`define DLCR_WDOG_TIMEOUT_HI 7
`define DLCR_WDOG_TIMEOUT_LO 1
`define DLCR_BIT_WDOG_OFF 0

// Field positions, serial bus control one
`define DLCR_BIT_PASS_ALL 7
`define DLCR_SDA_HOLD_HI 6
`define DLCR_SDA_HOLD_LO 4
`define DLCR_GLITCH_HI 3
`define DLCR_GLITCH_LO 0

// Timing
`define DLCR_CLK_NS 50
`define DLCR_TIMEOUT_UNIT_MS 2
`define DLCR_TIMEOUT_UNIT_CYC ((`DLCR_TIMEOUT_UNIT_MS * 1000000) / `DLCR_CLK_NS)
`define DLCR_SYNC_MIN_PCLK 2

`endif

/* File: dlcr_pkg.sv */
package dlcr_pkg;

typedef struct packed {
    logic wr;       // Write strobe, one cycle
    logic rd;       // Read strobe, one cycle
    logic [7:0] addr;
    logic [7:0] wdata;
} dlcr_bus_req_t;

typedef struct packed {
    logic valid;    // Read data valid pulse
    logic hit;      // Address mapped
    logic [7:0] rdata;
} dlcr_bus_rsp_t;

typedef struct packed {
    logic pixel_valid;
    logic line_sync;
    logic frame_sync;
} dlcr_sync_t;

typedef struct packed {
    logic check_gen_on;
    logic idle_pull_low;
    logic pass_decoded;
    logic pass_all;
    logic auto_ack;
    logic colour_mask;
    logic [2:0] sda_hold_steps;
    logic [3:0] glitch_steps;
} dlcr_cfg_t;

endpackage

/* File: dlcr_regs.sv */
// Functional notes
// - Bit 6 of general config one: 0 enables back-link check generator, 1 disables; resets 1.
// - Bit 5 selects idle input pull: 1 pulls low, 0 pulls high; resets 1.
// - Bit 4 set rejects sync/valid pulses shorter than two pixel clocks.
// - Bit 3 set forwards local transactions whose address decodes to remote target.
// - Bit 2 set acknowledges incoming writes regardless of forward link lock.
// - Bit 1 masks colour by pixel_valid; protected serializer forces this masking whatever bit 1 holds.
// - Watchdog bits 7:1 give timeout in 2 ms steps; reset 0x7F.
// - Enabled watchdog ends any link transaction exceeding the programmed timeout.
// - Watchdog bit 0: 1 disables, 0 enables; resets 0.
// - Bus control bit 7 set forwards every local transaction regardless of decode.
// - Bits 6:4 set internal SDA hold in 50 ns steps; reset 0x1.
// - Bits 3:0 set widest rejected SCL/SDA glitch in 5 ns steps; reset 0xE.
`timescale 1ns/100ps
`default_nettype none
`include "dlcr_params.svh"

module dlcr_regs #(
    parameter int unsigned TIMEOUT_UNIT_CYC = `DLCR_TIMEOUT_UNIT_CYC
) (
    input wire logic clk_sys,                        // 20 MHz device clock
    input wire logic sys_rst,                        // Synchronous reset, high
    input wire dlcr_pkg::dlcr_bus_req_t bus_req,     // Register access request
    output var dlcr_pkg::dlcr_bus_rsp_t bus_rsp,     // Register read answer
    input wire logic pclk_en,                        // Pixel clock enable pulse
    input wire dlcr_pkg::dlcr_sync_t sync_in,        // Raw sync inputs from pins
    output var dlcr_pkg::dlcr_sync_t sync_out,       // Filtered sync outputs
    input wire logic [23:0] colour_in,               // Colour data, pixel rate
    input wire logic peer_protected,                 // Serializer has content protection
    output logic [23:0] colour_out,                  // Colour data after masking
    input wire logic txn_addr_decoded,               // Address matches remote target
    output logic txn_forward,                        // Forward current transaction
    input wire logic link_locked,                    // Forward link lock state
    output logic write_ack_ok,                       // Acknowledge incoming writes
    input wire logic link_txn_active,                // Link transaction in progress
    output logic link_txn_abort,                     // Watchdog end pulse
    output var dlcr_pkg::dlcr_cfg_t cfg              // Decoded configuration
);
    import dlcr_pkg::*;

    logic [7:0] general_config_one;
    logic [7:0] link_watchdog_control;
    logic [7:0] serial_bus_control_one;
    dlcr_sync_t sync_s1;
    dlcr_sync_t sync_s2;
    dlcr_sync_t sync_prev;
    logic [1:0] run_cnt [3];
    logic peer_s1;
    logic peer_s2;
    logic lock_s1;
    logic lock_s2;
    logic [31:0] unit_cnt;
    logic [6:0] step_cnt;
    logic [6:0] link_txn_timeout;
    logic link_txn_timeout_off;
    logic backlink_check_gen_off;
    logic idle_input_pull_select;
    logic colour_mask_by_valid;

    function automatic logic [7:0] read_mux(input logic [7:0] a);
        case (a)
            `DLCR_ADDR_GEN_CFG_ONE: read_mux = general_config_one;
            `DLCR_ADDR_WDOG_CTRL: read_mux = link_watchdog_control;
            `DLCR_ADDR_BUS_CTRL_ONE: read_mux = serial_bus_control_one;
            default: read_mux = 8'h00;
        endcase
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == `DLCR_ADDR_GEN_CFG_ONE) || (a == `DLCR_ADDR_WDOG_CTRL) ||
            (a == `DLCR_ADDR_BUS_CTRL_ONE);
    endfunction

    assign backlink_check_gen_off = general_config_one[`DLCR_BIT_CHECK_GEN_OFF];
    assign idle_input_pull_select = general_config_one[`DLCR_BIT_IDLE_PULL];
    assign colour_mask_by_valid = general_config_one[`DLCR_BIT_COLOUR_MASK];
    assign link_txn_timeout = link_watchdog_control[`DLCR_WDOG_TIMEOUT_HI:`DLCR_WDOG_TIMEOUT_LO];
    assign link_txn_timeout_off = link_watchdog_control[`DLCR_BIT_WDOG_OFF];

    // Register writes; reserved bits hold what was written
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            general_config_one <= `DLCR_RST_GEN_CFG_ONE;
            link_watchdog_control <= {`DLCR_RST_WDOG_TIMEOUT, `DLCR_RST_WDOG_OFF};
            serial_bus_control_one <= `DLCR_RST_BUS_CTRL_ONE;
        end else if (bus_req.wr) begin
            case (bus_req.addr)
                `DLCR_ADDR_GEN_CFG_ONE: general_config_one <= bus_req.wdata;
                `DLCR_ADDR_WDOG_CTRL: link_watchdog_control <= bus_req.wdata;
                `DLCR_ADDR_BUS_CTRL_ONE: serial_bus_control_one <= bus_req.wdata;
                default: ;
            endcase
        end
    end

    // Read answer; reads change no state
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            bus_rsp <= '0;
        end else begin
            bus_rsp.valid <= bus_req.rd;
            bus_rsp.hit <= bus_req.rd && is_mapped(bus_req.addr);
            bus_rsp.rdata <= bus_req.rd ? read_mux(bus_req.addr) : 8'h00;
        end
    end

    // Pin synchronisers
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sync_s1 <= '0;
            sync_s2 <= '0;
            peer_s1 <= 1'b0;
            peer_s2 <= 1'b0;
            lock_s1 <= 1'b0;
            lock_s2 <= 1'b0;
        end else begin
            sync_s1 <= sync_in;
            sync_s2 <= sync_s1;
            peer_s1 <= peer_protected;
            peer_s2 <= peer_s1;
            lock_s1 <= link_locked;
            lock_s2 <= lock_s1;
        end
    end

    // Sync filter: a level must hold two pixel clocks before it is passed
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sync_prev <= '0;
            sync_out <= '0;
            for (int i = 0; i < 3; i++) begin
                run_cnt[i] <= 2'h0;
            end
        end else if (pclk_en) begin
            sync_prev <= sync_s2;
            for (int i = 0; i < 3; i++) begin
                if (!general_config_one[`DLCR_BIT_SYNC_FILTER]) begin
                    sync_out[i] <= sync_s2[i];
                    run_cnt[i] <= 2'h0;
                end else if (sync_s2[i] != sync_prev[i]) begin
                    run_cnt[i] <= 2'h1;
                end else if (run_cnt[i] < 2'(`DLCR_SYNC_MIN_PCLK)) begin
                    run_cnt[i] <= run_cnt[i] + 2'h1;
                    if (run_cnt[i] + 2'h1 == 2'(`DLCR_SYNC_MIN_PCLK)) begin
                        sync_out[i] <= sync_s2[i];
                    end
                end
            end
        end
    end

    // Colour masking and forwarding / acknowledge decisions
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            colour_out <= 24'h000000;
            txn_forward <= 1'b0;
            write_ack_ok <= 1'b0;
        end else begin
            if ((colour_mask_by_valid || peer_s2) && !sync_out.pixel_valid) begin
                colour_out <= 24'h000000;
            end else begin
                colour_out <= colour_in;
            end
            txn_forward <= serial_bus_control_one[`DLCR_BIT_PASS_ALL] ||
                (general_config_one[`DLCR_BIT_PASS_DECODED] && txn_addr_decoded);
            write_ack_ok <= general_config_one[`DLCR_BIT_AUTO_ACK] || lock_s2;
        end
    end

    // Link transaction watchdog
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            unit_cnt <= 32'h0;
            step_cnt <= 7'h0;
            link_txn_abort <= 1'b0;
        end else begin
            link_txn_abort <= 1'b0;
            if (link_txn_timeout_off || !link_txn_active) begin
                unit_cnt <= 32'h0;
                step_cnt <= 7'h0;
            end else if (unit_cnt == TIMEOUT_UNIT_CYC - 1) begin
                unit_cnt <= 32'h0;
                if (step_cnt + 7'h1 >= link_txn_timeout) begin
                    link_txn_abort <= 1'b1;
                    step_cnt <= 7'h0;
                end else begin
                    step_cnt <= step_cnt + 7'h1;
                end
            end else begin
                unit_cnt <= unit_cnt + 32'h1;
            end
        end
    end

    // Configuration outputs
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cfg <= '0;
        end else begin
            cfg.check_gen_on <= !backlink_check_gen_off;
            cfg.idle_pull_low <= idle_input_pull_select;
            cfg.pass_decoded <= general_config_one[`DLCR_BIT_PASS_DECODED];
            cfg.pass_all <= serial_bus_control_one[`DLCR_BIT_PASS_ALL];
            cfg.auto_ack <= general_config_one[`DLCR_BIT_AUTO_ACK];
            cfg.colour_mask <= colour_mask_by_valid || peer_s2;
            cfg.sda_hold_steps <= serial_bus_control_one[`DLCR_SDA_HOLD_HI:`DLCR_SDA_HOLD_LO];
            cfg.glitch_steps <= serial_bus_control_one[`DLCR_GLITCH_HI:`DLCR_GLITCH_LO];
        end
    end

endmodule
`default_nettype wire

/* File: dlcr_regs_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module dlcr_regs_monitor (
    input wire logic clk_sys, // Clock
    input wire logic sys_rst, // Reset
    input wire dlcr_pkg::dlcr_bus_req_t bus_req, // Request
    input wire dlcr_pkg::dlcr_bus_rsp_t bus_rsp, // Answer
    input wire logic peer_protected, // Peer forces masking
    input wire logic txn_addr_decoded, // Decode hit
    input wire logic txn_forward, // Forward
    input wire logic write_ack_ok, // Write ack
    input wire logic link_txn_active, // Busy
    input wire logic link_txn_abort, // Abort
    input wire dlcr_pkg::dlcr_cfg_t cfg // Config
);
    import dlcr_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // Lone write, so the decoded view settles two edges later
    sequence s_gen_wr;
        bus_req.wr && bus_req.addr == 8'h03 ##1 !(bus_req.wr && bus_req.addr == 8'h03);
    endsequence
    sequence s_bus_wr;
        bus_req.wr && bus_req.addr == 8'h05 ##1 !(bus_req.wr && bus_req.addr == 8'h05);
    endsequence
    sequence s_settled;
        $stable(cfg) && $stable(txn_addr_decoded) ##1 $stable(cfg);
    endsequence
    a_read_strobe: assert property (bus_rsp.valid == $past(bus_req.rd))
        else $error("read strobe wrong");
    a_gen_fields: assert property (s_gen_wr |=>
        cfg.check_gen_on == !$past(bus_req.wdata[6], 2) && cfg.idle_pull_low ==
        $past(bus_req.wdata[5], 2) && {cfg.pass_decoded, cfg.auto_ack} ==
        $past(bus_req.wdata[3:2], 2) && cfg.colour_mask ==
        ($past(bus_req.wdata[1], 2) || $past(peer_protected, 3)))
        else $error("general fields wrong");
    a_bus_fields: assert property (s_bus_wr |=>
        {cfg.pass_all, cfg.sda_hold_steps, cfg.glitch_steps} == $past(bus_req.wdata, 2))
        else $error("bus fields wrong");
    a_write_readback: assert property ((bus_req.wr && bus_req.addr inside {8'h03, 8'h04, 8'h05})
        ##1 (bus_req.rd && !bus_req.wr && $stable(bus_req.addr)) |=>
        bus_rsp.rdata == $past(bus_req.wdata, 2)) else $error("readback wrong");
    a_forward_rule: assert property (s_settled |-> txn_forward ==
        (cfg.pass_all || cfg.pass_decoded && $past(txn_addr_decoded)))
        else $error("forward wrong");
    a_auto_ack: assert property (cfg.auto_ack && $past(cfg.auto_ack) |-> write_ack_ok)
        else $error("auto ack missing");
    a_abort_single: assert property (link_txn_abort |=> !link_txn_abort)
        else $error("abort too long");
    a_abort_cause: assert property (link_txn_abort |-> $past(link_txn_active))
        else $error("abort without transaction");
endmodule
bind dlcr_regs dlcr_regs_monitor u_monitor (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .bus_req(bus_req), .bus_rsp(bus_rsp), .peer_protected(peer_protected),
    .txn_addr_decoded(txn_addr_decoded),
    .txn_forward(txn_forward), .write_ack_ok(write_ack_ok),
    .link_txn_active(link_txn_active), .link_txn_abort(link_txn_abort), .cfg(cfg));
`default_nettype wire

/* File: dlcr_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module dlcr_host_model (
    input wire logic clk_sys, // Clock
    output var dlcr_pkg::dlcr_bus_req_t bus_req, // Request
    input wire dlcr_pkg::dlcr_bus_rsp_t bus_rsp // Answer
);
    import dlcr_pkg::*;
    initial bus_req = '0;
    task automatic drive(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus_req <= '{wr: w, rd: r, addr: a, wdata: d};
    endtask
    // Released lines show inverted values, never stale ones
    task automatic release_bus();
        @(posedge clk_sys);
        bus_req <= '{wr: 1'b0, rd: 1'b0, addr: ~bus_req.addr, wdata: ~bus_req.wdata};
    endtask
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        drive(1'b1, 1'b0, a, d);
        release_bus();
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output dlcr_bus_rsp_t q);
        if (w) drive(1'b1, 1'b0, a, d);
        drive(1'b0, 1'b1, a, d);
        release_bus();
        @(posedge clk_sys);
        q = bus_rsp;
    endtask
endmodule
`default_nettype wire

/* File: deser_link_config_regs_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_mismatch++; \
    $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end
module deser_link_config_regs_tb;
    import dlcr_pkg::*;
    localparam int UNIT = 4;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic pclk_en = 1'b1;
    logic peer_protected = 1'b0;
    logic txn_addr_decoded = 1'b0;
    logic link_locked = 1'b0;
    logic link_txn_active = 1'b0;
    logic [23:0] colour_in = 24'hABCDEF;
    logic [23:0] colour_out;
    logic txn_forward, write_ack_ok, link_txn_abort, s;
    dlcr_sync_t sync_in = '0;
    dlcr_sync_t sync_out;
    dlcr_bus_req_t bus_req;
    dlcr_bus_rsp_t bus_rsp, q;
    dlcr_cfg_t cfg;
    logic [7:0] pat [2] = '{8'h55, 8'hAA};
    int n_mismatch = 0;
    int check_count = 0;
    int n;
    dlcr_regs #(.TIMEOUT_UNIT_CYC(UNIT)) u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .bus_req(bus_req), .bus_rsp(bus_rsp), .pclk_en(pclk_en), .sync_in(sync_in),
        .sync_out(sync_out), .colour_in(colour_in), .peer_protected(peer_protected),
        .colour_out(colour_out), .txn_addr_decoded(txn_addr_decoded),
        .txn_forward(txn_forward), .link_locked(link_locked), .write_ack_ok(write_ack_ok),
        .link_txn_active(link_txn_active), .link_txn_abort(link_txn_abort), .cfg(cfg));
    dlcr_host_model u_host (.clk_sys(clk_sys), .bus_req(bus_req), .bus_rsp(bus_rsp));
    initial forever #25 clk_sys = ~clk_sys;
    task automatic settle(input int k);
        repeat (k) @(posedge clk_sys);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        settle(5000);
        n_mismatch++;
        finish_test();
    end
    initial begin
        settle(4);
        sys_rst <= 1'b0;
        u_host.xfer(1'b0, 8'h03, 8'h00, q); `CHK(q, 10'h3F0)
        u_host.xfer(1'b0, 8'h04, 8'h00, q); `CHK(q, 10'h3FE)
        u_host.xfer(1'b0, 8'h05, 8'h00, q); `CHK(q, 10'h31E)
        u_host.write_reg(8'h06, 8'hFF);
        u_host.xfer(1'b0, 8'h06, 8'h00, q); `CHK(q, 10'h200)
        `CHK(cfg, 13'h081E)
        $display("test reset done");
        foreach (pat[i]) for (int a = 3; a <= 5; a++) begin
            u_host.xfer(1'b1, 8'(a), pat[i], q); `CHK(q.rdata, pat[i])
            u_host.xfer(1'b0, 8'(a), 8'h00, q); `CHK(q.rdata, pat[i])
        end
        $display("test readback done");
        u_host.write_reg(8'h05, 8'h80);
        u_host.write_reg(8'h03, 8'h00);
        settle(3); `CHK(txn_forward, 1'b1)
        `CHK(cfg.check_gen_on, 1'b1)
        `CHK(cfg.idle_pull_low, 1'b0)
        u_host.write_reg(8'h05, 8'h1E);
        @(posedge clk_sys) txn_addr_decoded <= 1'b1;
        settle(3); `CHK(txn_forward, 1'b0)
        u_host.write_reg(8'h03, 8'h08);
        settle(3); `CHK(txn_forward, 1'b1)
        u_host.write_reg(8'h03, 8'h04);
        settle(3); `CHK(write_ack_ok, 1'b1)
        u_host.write_reg(8'h03, 8'h00);
        settle(3); `CHK(write_ack_ok, 1'b0)
        $display("test forward done");
        for (int c = 0; c < 8; c++) begin
            u_host.write_reg(8'h03, c[2] ? 8'h02 : 8'h00);
            @(posedge clk_sys) {sync_in.pixel_valid, peer_protected} <= 2'(c);
            settle(8);
            `CHK(colour_out, ((c[2] | c[0]) & !c[1]) ? 24'h0 : 24'hABCDEF)
        end
        $display("test masking done");
        for (int i = 0; i < 4; i++) begin
            u_host.write_reg(8'h03, i[1] ? 8'h10 : 8'h00);
            @(posedge clk_sys) sync_in.frame_sync <= 1'b1;
            settle(i[0] + 1);
            sync_in.frame_sync <= 1'b0;
            s = 1'b0;
            repeat (10) begin @(posedge clk_sys); s = s | sync_out.frame_sync; end
            `CHK(s, !i[1] || i[0])
        end
        $display("test filter done");
        for (int t = 1; t <= 3; t += 2) begin
            u_host.write_reg(8'h04, 8'(t << 1));
            @(posedge clk_sys) link_txn_active <= 1'b1;
            n = 0;
            while (!link_txn_abort && n < 100) begin @(posedge clk_sys); n++; end
            `CHK(n >= t * UNIT && n <= t * UNIT + 3, 1'b1)
            @(posedge clk_sys) link_txn_active <= 1'b0;
        end
        u_host.write_reg(8'h04, 8'h03);
        @(posedge clk_sys) link_txn_active <= 1'b1;
        s = 1'b0;
        repeat (40) begin @(posedge clk_sys); s = s | link_txn_abort; end
        `CHK(s, 1'b0)
        $display("test watchdog done");
        finish_test();
    end
endmodule
`default_nettype wire
